// ---- core/tcrb_timer.sv ----
// Functional notes
// - Counts divided clock or external falling edges
// - Counter advances only while run bit set
// - Wrap sets flag, pin high one cycle
// - Overflow flag only without serial selects; software clears
// - Writing one to a flag raises interrupt
// - Trigger capture/reload sets external flag; software clears
// - Trigger ignored when disabled; while baud generating it only sets the flag
// - Receive select routes overflow to receive clock
// - Transmit select routes overflow to transmit clock
// - Timer ticks every 4 or 12 clocks
// - Trigger edge copies count into capture registers
// - Reload mode wrap reloads count from capture
// - Trigger edge forces immediate reload
// - Serial selects force auto-reload operation
// - Baud overflow gives shift pulse, no flag
// - Baud time base is clock divided two
// - Shift clock serves serial port 0 only
// - Count held as low and high bytes
module tcrb_timer
    import tcrb_pkg::*;
(
    input  wire logic          core_clk,             // Core clock, 20 MHz
    input  wire logic          resetn,               // Synchronous reset, active low
    input  wire logic          clk_en,               // Freezes all state while low
    input  wire tcrb_sfr_req_t sfr_req,              // Register access request
    output logic [7:0]         sfr_rdata,            // Read data, one cycle after rd
    input  wire logic          external_count_pin,   // External count input
    input  wire logic          trigger_pin,          // Capture/reload trigger input
    input  wire logic          other_timer_overflow, // Overflow pulse of the other timer
    input  wire logic [1:0]    serial0_mode,         // Serial port 0 mode
    input  wire logic          interrupt_enable,     // Timer interrupt enable
    output logic               overflow_output_pin,  // One-cycle overflow pulse
    output logic               timer_irq,            // Interrupt request level
    output logic               serial0_rx_clk,       // Serial port 0 receive shift pulse
    output logic               serial0_tx_clk        // Serial port 0 transmit shift pulse
);

    // ****************************************************************
    // State
    // ****************************************************************
    tcrb_control_t control;           // Control and status register
    logic          rate_fast;         // Tick-rate bit of clock control
    logic [7:0]    count_low_byte;    // Count, low byte
    logic [7:0]    count_high_byte;   // Count, high byte
    logic [7:0]    capture_low_byte;  // Capture/reload, low byte
    logic [7:0]    capture_high_byte; // Capture/reload, high byte
    logic [3:0]    prescale;          // Core clocks since last tick
    logic [2:0]    count_sync;        // Count pin: two sync stages and history
    logic [2:0]    trig_sync;         // Trigger pin: two sync stages and history

    // ****************************************************************
    // Next values
    // ****************************************************************
    tcrb_control_t next_control;
    logic          next_rate_fast;
    logic [7:0]    next_count_low_byte;
    logic [7:0]    next_count_high_byte;
    logic [7:0]    next_capture_low_byte;
    logic [7:0]    next_capture_high_byte;
    logic [3:0]    next_prescale;
    logic [7:0]    next_sfr_rdata;
    logic          next_overflow_output_pin;
    logic          next_timer_irq;
    logic          next_serial0_rx_clk;
    logic          next_serial0_tx_clk;

    // ****************************************************************
    // Decoded conditions
    // ****************************************************************
    tcrb_mode_t    mode;              // Current operating mode
    logic [15:0]   count;             // Whole count
    logic [15:0]   capture;           // Whole capture value
    logic [3:0]    div_limit;         // Clocks per tick
    logic          count_fall;        // Falling edge on count pin
    logic          trig_fall;         // Falling edge on trigger pin
    logic          trig_event;        // Enabled trigger edge
    logic          tick;              // Counter advances this cycle
    logic          overflow;          // Count wraps this cycle
    logic          serial_timed;      // Serial port 0 uses timer clocks
    logic          wr_control;        // Write to control register

    assign count   = {count_high_byte, count_low_byte};
    assign capture = {capture_high_byte, capture_low_byte};

    // Stage 1 is only read by stage 2; edges look at stages 2 and 3
    assign count_fall = count_sync[2] & ~count_sync[1];
    assign trig_fall  = trig_sync[2] & ~trig_sync[1];

    // ****************************************************************
    // Mode, prescaler and tick decode
    // ****************************************************************
    always_comb begin
        // Serial selects override the capture/reload choice
        if (control.receive_clock_select | control.transmit_clock_select) begin
            mode = TCRB_MODE_BAUD;
        end else if (control.capture_reload_select) begin
            mode = TCRB_MODE_CAPTURE;
        end else begin
            mode = TCRB_MODE_RELOAD;
        end

        // Tick-rate bit has no say during baud generation
        if (mode == TCRB_MODE_BAUD) begin
            div_limit = TCRB_DIV_BAUD;
        end else if (rate_fast) begin
            div_limit = TCRB_DIV_FAST;
        end else begin
            div_limit = TCRB_DIV_SLOW;
        end

        // Prescaler restarts while stopped so the first tick is a full period
        next_prescale = TCRB_DIV_ZERO;
        tick          = 1'b0;
        if (control.run_control) begin
            if (control.counter_timer_select) begin
                tick = count_fall;
            end else if (prescale >= div_limit - TCRB_DIV_ONE) begin
                tick = 1'b1;
            end else begin
                next_prescale = prescale + TCRB_DIV_ONE;
            end
        end

        overflow = tick & (count == TCRB_COUNT_TOP);
        // Trigger edges count only while enabled
        trig_event = trig_fall & control.external_trigger_enable;
        wr_control = sfr_req.wr & (sfr_req.addr == TCRB_ADDR_CONTROL);
        serial_timed = (serial0_mode == TCRB_SER_MODE1) | (serial0_mode == TCRB_SER_MODE3);
    end

    // ****************************************************************
    // Count and capture next values
    // ****************************************************************
    always_comb begin
        logic [15:0] cnt_n;
        logic [15:0] cap_n;
        cnt_n = count;
        cap_n = capture;

        // Advance, reloading on wrap unless capturing
        if (tick) begin
            if (overflow && mode != TCRB_MODE_CAPTURE) begin
                cnt_n = capture;
            end else begin
                cnt_n = count + TCRB_COUNT_STEP;
            end
        end

        // Trigger edge acts on capture or reload, never in baud mode
        if (trig_event) begin
            unique case (mode)
                TCRB_MODE_CAPTURE: cap_n = count;
                TCRB_MODE_RELOAD:  cnt_n = capture;
                TCRB_MODE_BAUD:    cnt_n = cnt_n;
            endcase
        end

        // Software writes win over hardware on the byte written
        next_count_low_byte    = cnt_n[7:0];
        next_count_high_byte   = cnt_n[15:8];
        next_capture_low_byte  = cap_n[7:0];
        next_capture_high_byte = cap_n[15:8];
        next_rate_fast         = rate_fast;
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                TCRB_ADDR_CNT_LOW:   next_count_low_byte    = sfr_req.wdata;
                TCRB_ADDR_CNT_HIGH:  next_count_high_byte   = sfr_req.wdata;
                TCRB_ADDR_CAP_LOW:   next_capture_low_byte  = sfr_req.wdata;
                TCRB_ADDR_CAP_HIGH:  next_capture_high_byte = sfr_req.wdata;
                TCRB_ADDR_CLOCK_CTL: next_rate_fast = sfr_req.wdata[TCRB_POS_RATE_FAST];
                default:             next_rate_fast = rate_fast;
            endcase
        end
    end

    // ****************************************************************
    // Control, flags and outputs
    // ****************************************************************
    always_comb begin
        next_control = control;
        // A written one in a flag stands and so raises the request
        if (wr_control) begin
            next_control = tcrb_control_t'(sfr_req.wdata);
        end
        // Hardware set wins over a clearing write in the same cycle
        if (overflow && mode != TCRB_MODE_BAUD) begin
            next_control.overflow_flag = 1'b1;
        end
        if (trig_event) begin
            next_control.external_trigger_flag = 1'b1;
        end

        // Pin pulse on every wrap, flag or not
        next_overflow_output_pin = overflow;
        next_timer_irq = interrupt_enable
                         & (control.overflow_flag | control.external_trigger_flag);

        // Shift pulses go to serial port 0 only; port 1 has no path here
        next_serial0_rx_clk = 1'b0;
        next_serial0_tx_clk = 1'b0;
        if (serial_timed) begin
            next_serial0_rx_clk = control.receive_clock_select
                                  ? (overflow & (mode == TCRB_MODE_BAUD))
                                  : other_timer_overflow;
            next_serial0_tx_clk = control.transmit_clock_select
                                  ? (overflow & (mode == TCRB_MODE_BAUD))
                                  : other_timer_overflow;
        end

        // Registered read answer; unmapped addresses read zero
        next_sfr_rdata = sfr_rdata;
        if (sfr_req.rd) begin
            unique case (sfr_req.addr)
                TCRB_ADDR_CONTROL:   next_sfr_rdata = control;
                TCRB_ADDR_CAP_LOW:   next_sfr_rdata = capture_low_byte;
                TCRB_ADDR_CAP_HIGH:  next_sfr_rdata = capture_high_byte;
                TCRB_ADDR_CNT_LOW:   next_sfr_rdata = count_low_byte;
                TCRB_ADDR_CNT_HIGH:  next_sfr_rdata = count_high_byte;
                TCRB_ADDR_CLOCK_CTL: next_sfr_rdata = {2'h0, rate_fast, 5'h00};
                default:             next_sfr_rdata = TCRB_READ_NONE;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            control             <= tcrb_control_t'(TCRB_CONTROL_RESET);
            rate_fast           <= 1'b0;
            count_low_byte      <= TCRB_COUNT_RESET[7:0];
            count_high_byte     <= TCRB_COUNT_RESET[15:8];
            capture_low_byte    <= TCRB_CAPTURE_RESET[7:0];
            capture_high_byte   <= TCRB_CAPTURE_RESET[15:8];
            prescale            <= TCRB_DIV_ZERO;
            count_sync          <= 3'h7;
            trig_sync           <= 3'h7;
            sfr_rdata           <= TCRB_READ_NONE;
            overflow_output_pin <= 1'b0;
            timer_irq           <= 1'b0;
            serial0_rx_clk      <= 1'b0;
            serial0_tx_clk      <= 1'b0;
        end else if (clk_en) begin
            control             <= next_control;
            rate_fast           <= next_rate_fast;
            count_low_byte      <= next_count_low_byte;
            count_high_byte     <= next_count_high_byte;
            capture_low_byte    <= next_capture_low_byte;
            capture_high_byte   <= next_capture_high_byte;
            prescale            <= next_prescale;
            count_sync          <= {count_sync[1:0], external_count_pin};
            trig_sync           <= {trig_sync[1:0], trigger_pin};
            sfr_rdata           <= next_sfr_rdata;
            overflow_output_pin <= next_overflow_output_pin;
            timer_irq           <= next_timer_irq;
            serial0_rx_clk      <= next_serial0_rx_clk;
            serial0_tx_clk      <= next_serial0_tx_clk;
        end
    end

endmodule

// ---- core/tcrb_pkg.sv ----
// ****************************************************************
// Timer two package: addresses, layouts, reset values, counts
// ****************************************************************
package tcrb_pkg;

    // ****************************************************************
    // Special-function register addresses
    // ****************************************************************
    localparam logic [7:0] TCRB_ADDR_CONTROL   = 8'hc8; // timer_two_control
    localparam logic [7:0] TCRB_ADDR_CAP_LOW   = 8'hca; // capture_low_byte
    localparam logic [7:0] TCRB_ADDR_CAP_HIGH  = 8'hcb; // capture_high_byte
    localparam logic [7:0] TCRB_ADDR_CNT_LOW   = 8'hcc; // count_low_byte
    localparam logic [7:0] TCRB_ADDR_CNT_HIGH  = 8'hcd; // count_high_byte
    localparam logic [7:0] TCRB_ADDR_CLOCK_CTL = 8'h8e; // clock_control_register

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TCRB_POS_RATE_FAST = 5;              // Tick-rate bit in clock control

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  TCRB_CONTROL_RESET = 8'h00;  // All control bits clear
    localparam logic [15:0] TCRB_COUNT_RESET   = 16'h0000; // Count after reset
    localparam logic [15:0] TCRB_CAPTURE_RESET = 16'h0000; // Capture after reset
    localparam logic [15:0] TCRB_COUNT_TOP     = 16'hffff; // Last value before wrap
    localparam logic [15:0] TCRB_COUNT_STEP    = 16'h0001; // Increment
    localparam logic [7:0]  TCRB_READ_NONE     = 8'h00;  // Unmapped read answer

    // ****************************************************************
    // Core clocks per tick
    // ****************************************************************
    localparam logic [3:0] TCRB_DIV_SLOW = 4'hc;        // Default rate, 12 clocks
    localparam logic [3:0] TCRB_DIV_FAST = 4'h4;        // Fast rate, 4 clocks
    localparam logic [3:0] TCRB_DIV_BAUD = 4'h2;        // Baud generation, 2 clocks
    localparam logic [3:0] TCRB_DIV_ZERO = 4'h0;        // Prescaler restart
    localparam logic [3:0] TCRB_DIV_ONE  = 4'h1;        // Prescaler step

    // ****************************************************************
    // Serial port 0 modes that take timer overflows
    // ****************************************************************
    localparam logic [1:0] TCRB_SER_MODE1 = 2'h1;       // Async 8-bit
    localparam logic [1:0] TCRB_SER_MODE3 = 2'h3;       // Async 9-bit

    // ****************************************************************
    // Types
    // ****************************************************************
    // Control register, bit 7 first
    typedef struct packed {
        logic overflow_flag;
        logic external_trigger_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_trigger_enable;
        logic run_control;
        logic counter_timer_select;
        logic capture_reload_select;
    } tcrb_control_t;

    // Register access from the core
    typedef struct packed {
        logic       rd;      // Read strobe
        logic       wr;      // Write strobe
        logic [7:0] addr;    // Register address
        logic [7:0] wdata;   // Write data
    } tcrb_sfr_req_t;

    // Operating mode
    typedef enum logic [2:0] {
        TCRB_MODE_CAPTURE = 3'b001,
        TCRB_MODE_RELOAD  = 3'b010,
        TCRB_MODE_BAUD    = 3'b100
    } tcrb_mode_t;

endpackage

// ---- testbench/tcrb_timer_assertions.sv ----
// ****************************************************************
// Port-level checks for timer two
// ****************************************************************
module tcrb_timer_checker
    import tcrb_pkg::*;
(
    input wire logic          core_clk,             // Core clock
    input wire logic          resetn,               // Sync reset, active low
    input wire logic          clk_en,               // Clock enable
    input wire tcrb_sfr_req_t sfr_req,              // Register request
    input wire logic [7:0]    sfr_rdata,            // Read data
    input wire logic          external_count_pin,   // Count pin
    input wire logic          trigger_pin,          // Trigger pin
    input wire logic          other_timer_overflow, // Other timer pulse
    input wire logic [1:0]    serial0_mode,         // Serial mode
    input wire logic          interrupt_enable,     // Interrupt enable
    input wire logic          overflow_output_pin,  // Wrap pulse
    input wire logic          timer_irq,            // Interrupt level
    input wire logic          serial0_rx_clk,       // Receive shift pulse
    input wire logic          serial0_tx_clk        // Transmit shift pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] shadow;      // Rate bit over software control bits
    logic [6:0] next_shadow; // Next shadow
    logic       mode_ok;     // Serial mode takes timer overflows
    logic       baud_sel;    // Either serial select set
    logic       rx_sel;      // Receive clock from this timer
    logic       tx_sel;      // Transmit clock from this timer
    logic       plain;       // Plain timer function, no baud
    assign mode_ok  = (serial0_mode == TCRB_SER_MODE1) || (serial0_mode == TCRB_SER_MODE3);
    assign baud_sel = shadow[5] | shadow[4];
    assign rx_sel   = shadow[5] & mode_ok;
    assign tx_sel   = shadow[4] & mode_ok;
    assign plain    = !baud_sel && !shadow[1];
    // Mirror software bits only
    always_comb begin
        next_shadow = shadow;
        if (clk_en && sfr_req.wr && sfr_req.addr == TCRB_ADDR_CONTROL) begin
            next_shadow[5:0] = sfr_req.wdata[5:0];
        end
        if (clk_en && sfr_req.wr && sfr_req.addr == TCRB_ADDR_CLOCK_CTL) begin
            next_shadow[6] = sfr_req.wdata[TCRB_POS_RATE_FAST];
        end
    end
    // Shadow register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            shadow <= 7'h00;
        end else begin
            shadow <= next_shadow;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Wrap pulse, then a quiet cycle
    sequence s_pulse_quiet;
        overflow_output_pin ##1 !overflow_output_pin;
    endsequence
    // Plain timer wrap at either rate
    sequence s_slow_wrap;
        overflow_output_pin && plain && !shadow[6];
    endsequence
    sequence s_fast_wrap;
        overflow_output_pin && plain && shadow[6];
    endsequence
    a_pulse_single: assert property (overflow_output_pin |-> s_pulse_quiet)
        else $error("Overflow pulse longer than one cycle");
    a_slow_gap: assert property (s_slow_wrap |=> !overflow_output_pin [*8])
        else $error("Slow timer wrapped too soon");
    a_fast_gap: assert property (s_fast_wrap |=> !overflow_output_pin [*3])
        else $error("Fast timer wrapped too soon");
    a_run_gates: assert property (overflow_output_pin |-> $past(shadow[2]))
        else $error("Wrap while stopped");
    a_irq_on_wrap: assert property (overflow_output_pin && interrupt_enable
        && !$past(baud_sel) |=> timer_irq)
        else $error("No interrupt after timer wrap");
    a_rx_route: assert property ($past(rx_sel) |-> serial0_rx_clk == overflow_output_pin)
        else $error("Receive clock not this timer wrap");
    a_tx_route: assert property ($past(tx_sel) |-> serial0_tx_clk == overflow_output_pin)
        else $error("Transmit clock not this timer wrap");
    a_rx_other: assert property (other_timer_overflow && mode_ok && !shadow[5] |=> serial0_rx_clk)
        else $error("Other timer pulse not passed");
    a_clk_mode_gate: assert property (serial0_rx_clk || serial0_tx_clk |-> $past(mode_ok))
        else $error("Shift pulse outside modes 1 and 3");
endmodule

bind tcrb_timer tcrb_timer_checker u_checker (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .external_count_pin(external_count_pin), .trigger_pin(trigger_pin),
    .other_timer_overflow(other_timer_overflow), .serial0_mode(serial0_mode),
    .interrupt_enable(interrupt_enable), .overflow_output_pin(overflow_output_pin), .timer_irq(timer_irq),
    .serial0_rx_clk(serial0_rx_clk), .serial0_tx_clk(serial0_tx_clk)
);

// ---- testbench/tcrb_far_side.sv ----
// ****************************************************************
// Far side: count and trigger sources, other timer
// ****************************************************************
module tcrb_far_side (
    input  wire logic core_clk,  // Core clock
    output logic      count_pin, // Count source, idles high
    output logic      trig_pin,  // Trigger source, idles high
    output logic      other_ovf  // Other timer wrap pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    int div = 0; // Other timer divider
    // Pins idle high, no pulse yet
    initial begin
        count_pin = 1'b1;
        trig_pin  = 1'b1;
        other_ovf = 1'b0;
    end
    // Other timer wraps every 7 clocks
    always @(posedge core_clk) begin
        #1;
        div       = (div + 1) % 7;
        other_ovf = (div == 0);
    end
    // Held 3 clocks so the synchroniser sees it
    task automatic fall(input logic trig, input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
            {trig_pin, count_pin} = trig ? 2'b01 : 2'b10;
            repeat (3) @(posedge core_clk);
            #1;
            {trig_pin, count_pin} = 2'b11;
            repeat (3) @(posedge core_clk);
        end
    endtask
endmodule

// ---- testbench/testbench.sv ----
// ****************************************************************
// Timer two testbench
// ****************************************************************
module testbench
    import tcrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] addr;  // Register, or rate value
        logic [7:0] wdata; // Value written
        logic [7:0] rdata; // Expected readback, or wrap gap
    } tcrb_row_t;
    localparam tcrb_row_t ROWS [7] = '{'{8'hca, 8'h5a, 8'h5a}, '{8'hcb, 8'ha5, 8'ha5}, '{8'hcc, 8'h3c, 8'h3c},
        '{8'hcd, 8'hc3, 8'hc3}, '{8'h8e, 8'hff, 8'h20}, '{8'hc8, 8'h0b, 8'h0b}, '{8'hf0, 8'h77, 8'h00}};
    localparam tcrb_row_t RUNS [3] = '{'{8'h00, 8'h04, 8'h0c}, '{8'h20, 8'h04, 8'h04}, '{8'h20, 8'h34, 8'h02}};
    logic          core_clk         = 1'b0; // 20 MHz clock
    logic          resetn           = 1'b0; // Held low at start
    logic          clk_en           = 1'b1; // Always enabled
    tcrb_sfr_req_t sfr_req          = '0;   // Register request
    logic [7:0]    sfr_rdata;               // Read data
    logic [1:0]    serial0_mode     = 2'h1; // Async 8-bit
    logic          interrupt_enable = 1'b0; // Interrupt enable
    logic          count_pin;               // From far side
    logic          trig_pin;                // From far side
    logic          other_ovf;               // From far side
    logic          ovf_pin;                 // Wrap pulse
    logic          irq;                     // Interrupt level
    logic [7:0]    rd_val;                  // Last read result
    int            errors           = 0;    // Mismatches
    int            n_compared       = 0;    // Comparisons
    always #25 core_clk = ~core_clk;
    tcrb_timer DUT (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .external_count_pin(count_pin), .trigger_pin(trig_pin), .other_timer_overflow(other_ovf),
        .serial0_mode(serial0_mode), .interrupt_enable(interrupt_enable), .overflow_output_pin(ovf_pin),
        .timer_irq(irq), .serial0_rx_clk(), .serial0_tx_clk()
    );
    tcrb_far_side far (.core_clk(core_clk), .count_pin(count_pin), .trig_pin(trig_pin), .other_ovf(other_ovf));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
        n_compared++;
        if (seen !== expected) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, expected, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One strobe cycle; read data after the edge
    task automatic sfr_access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
        @(posedge core_clk);
        #1;
        sfr_req = '{rd, !rd, addr, wdata};
        @(posedge core_clk);
        #1;
        sfr_req = '0;
        rd_val  = sfr_rdata;
    endtask
    task automatic read_check(input string what, input logic [7:0] addr, input logic [7:0] expected);
        sfr_access(1'b1, addr, 8'h00);
        check(what, rd_val, expected);
    endtask
    // Bounded wait for a wrap, gap in clocks
    task automatic wait_pulse(output int gap);
        gap = 0;
        do begin
            @(posedge core_clk);
            #1;
            gap++;
        end while (ovf_pin !== 1'b1 && gap < 100);
        if (ovf_pin !== 1'b1) begin
            errors++;
            report_and_stop();
        end
    endtask
    initial begin
        int gap;
        repeat (16) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        read_check("count after reset", TCRB_ADDR_CNT_LOW, 8'h00);
        foreach (ROWS[i]) begin
            sfr_access(1'b0, ROWS[i].addr, ROWS[i].wdata);
            read_check("register readback", ROWS[i].addr, ROWS[i].rdata);
        end
        sfr_access(1'b0, TCRB_ADDR_CAP_LOW, 8'hff);
        sfr_access(1'b0, TCRB_ADDR_CAP_HIGH, 8'hff);
        interrupt_enable = 1'b1;
        // Reload from ffff: a wrap per tick
        foreach (RUNS[i]) begin
            sfr_access(1'b0, TCRB_ADDR_CLOCK_CTL, RUNS[i].addr);
            sfr_access(1'b0, TCRB_ADDR_CNT_LOW, 8'hff);
            sfr_access(1'b0, TCRB_ADDR_CNT_HIGH, 8'hff);
            sfr_access(1'b0, TCRB_ADDR_CONTROL, RUNS[i].wdata);
            wait_pulse(gap);
            wait_pulse(gap);
            check("clocks between wraps", 8'(gap), RUNS[i].rdata);
            read_check("control running", 8'hc8, RUNS[i].wdata | {!RUNS[i].wdata[4], 7'h00});
            check("interrupt level", {7'h00, irq}, {7'h00, !RUNS[i].wdata[4]});
            sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h00);
        end
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h40);
        @(posedge core_clk);
        #1;
        check("interrupt after flag write", {7'h00, irq}, 8'h01);
        interrupt_enable = 1'b0;
        @(posedge core_clk);
        #1;
        check("interrupt while disabled", {7'h00, irq}, 8'h00);
        interrupt_enable = 1'b1;
        // Capture refused, then taken
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h01);
        sfr_access(1'b0, TCRB_ADDR_CNT_LOW, 8'h34);
        sfr_access(1'b0, TCRB_ADDR_CNT_HIGH, 8'h12);
        far.fall(1'b1, 1);
        read_check("capture ignored", TCRB_ADDR_CAP_LOW, 8'hff);
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h09);
        far.fall(1'b1, 1);
        read_check("capture low", TCRB_ADDR_CAP_LOW, 8'h34);
        read_check("capture high", TCRB_ADDR_CAP_HIGH, 8'h12);
        read_check("external flag", TCRB_ADDR_CONTROL, 8'h49);
        // Forced reload, then trigger in baud mode
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h08);
        sfr_access(1'b0, TCRB_ADDR_CNT_HIGH, 8'h00);
        far.fall(1'b1, 1);
        read_check("reloaded count", TCRB_ADDR_CNT_HIGH, 8'h12);
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h18);
        sfr_access(1'b0, TCRB_ADDR_CNT_HIGH, 8'h00);
        far.fall(1'b1, 1);
        read_check("count in baud mode", TCRB_ADDR_CNT_HIGH, 8'h00);
        read_check("flag in baud mode", TCRB_ADDR_CONTROL, 8'h58);
        serial0_mode = 2'h2;
        // Pin edges count only while running
        sfr_access(1'b0, TCRB_ADDR_CNT_LOW, 8'h00);
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h06);
        far.fall(1'b0, 5);
        sfr_access(1'b0, TCRB_ADDR_CONTROL, 8'h02);
        far.fall(1'b0, 2);
        read_check("external count", TCRB_ADDR_CNT_LOW, 8'h05);
        report_and_stop();
    end
endmodule
